/* File: spr_core.sv */
`timescale 1ns/1ns
// Summary of operation
// - six word registers at addresses zero to five
// - undefined data bits read zero, writes ignored
// - full received word loads holding, sets full
// - reading receive holding clears full; writes ignored
// - new word always loads; full and no read that cycle sets overrun
// - transmit write while empty clears transmit empty
// - transfer to shifter sets transmit empty again
// - write while not empty: overrun, data discarded
// - held word waits until current shift ends
// - status read harmless; status write clears errors
// - master: idle low during transfer, high empty
// - slave: idle low when selected or unready
// - error flag is OR of both overruns
// - select mask and force only in master
// - interrupt when flag and its enable set
// - force bit drives masked selects always
// - reset clears all control bits
// - reset selects target zero only

// ****************************************************************
// register interface of the serial core
// ****************************************************************
module spr_core #(
  parameter bit IS_MASTER = 1'b1  // build as master (1) or slave (0)
) (
  input  wire logic                          CLOCK_IN,
  input  wire logic                          NRST_IN,
  input  wire logic [spr_pkg::ADDR_W-1:0]    ADDR_IN,       // internal word address
  input  wire logic                          RD_IN,         // read strobe
  input  wire logic                          WR_IN,         // write strobe
  input  wire logic [spr_pkg::BUS_W-1:0]     WDATA_IN,      // write data
  output logic      [spr_pkg::BUS_W-1:0]     RDATA_OUT,     // read data, one cycle late
  output logic                               IRQ_OUT,       // interrupt request, high
  output logic                               SCLK_OUT,      // serial clock
  output logic                               MOSI_OUT,      // serial data out
  input  wire logic                          MISO_IN,       // serial data in
  input  wire logic                          SEL_N_IN,      // slave select in, low
  output logic      [spr_pkg::SEL_W-1:0]     SEL_N_OUT      // target selects, low
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [spr_pkg::DATA_W-1:0]  rx_hold;      // receive holding register
    logic [spr_pkg::DATA_W-1:0]  tx_hold;      // transmit holding register
    logic                        rx_full;      // receive_full_flag
    logic                        tx_empty;     // transmit_empty_flag
    logic                        rx_ovr;       // receive_overrun_flag
    logic                        tx_ovr;       // transmit_overrun_flag
    logic [spr_pkg::CTRL_W-1:0]  control;      // control register
    logic [spr_pkg::SEL_W-1:0]   sel_mask;     // target select mask
    logic [spr_pkg::SEL_W-1:0]   sel_n;        // registered select pins
    logic [spr_pkg::BUS_W-1:0]   rdata;        // registered read data
    logic                        load;         // start pulse to engine
    logic [spr_pkg::DATA_W-1:0]  load_data;    // word handed to engine
  } spr_core_state_t;

  spr_core_state_t st;       // current state
  spr_core_state_t next_st;  // next state

  spr_shift_if sh ();        // link to the shift engine

  logic                        miso_sync;    // filtered serial input
  logic                        sel_sync_n;   // filtered slave select
  logic                        shifter_idle; // shifter_idle_flag
  logic                        error_flag;   // error summary
  logic [spr_pkg::BUS_W-1:0]   status_word;  // assembled status
  logic                        wr_rx;        // decoded strobes
  logic                        wr_tx;
  logic                        wr_stat;
  logic                        wr_ctrl;
  logic                        wr_sel;
  logic                        rd_rx;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  spr_sync3 #(
    .IDLE_LEVEL (1'b0)
  ) u_sync_miso (
    .clk_in    (CLOCK_IN),
    .nrst_in   (NRST_IN),
    .pin_in    (MISO_IN),
    .level_out (miso_sync)
  );

  // select idles high so an idle slave looks deselected
  spr_sync3 #(
    .IDLE_LEVEL (1'b1)
  ) u_sync_sel (
    .clk_in    (CLOCK_IN),
    .nrst_in   (NRST_IN),
    .pin_in    (SEL_N_IN),
    .level_out (sel_sync_n)
  );

  // ****************************************************************
  // shift engine
  // ****************************************************************
  spr_shift u_shift (
    .clk_in   (CLOCK_IN),
    .nrst_in  (NRST_IN),
    .sh       (sh.engine),
    .miso_in  (miso_sync),
    .sclk_out (SCLK_OUT),
    .mosi_out (MOSI_OUT)
  );

  assign sh.load      = st.load;
  assign sh.load_data = st.load_data;

  // ****************************************************************
  // address decode
  // ****************************************************************
  // the receive holding write is decoded but wr_rx is never used: such writes are dropped
  assign wr_rx   = WR_IN && (ADDR_IN == spr_pkg::ADDR_RX_HOLD);
  assign wr_tx   = WR_IN && (ADDR_IN == spr_pkg::ADDR_TX_HOLD);
  assign wr_stat = WR_IN && (ADDR_IN == spr_pkg::ADDR_STATUS);
  assign wr_ctrl = WR_IN && (ADDR_IN == spr_pkg::ADDR_CONTROL);
  assign wr_sel  = WR_IN && (ADDR_IN == spr_pkg::ADDR_SEL) && IS_MASTER;
  assign rd_rx   = RD_IN && (ADDR_IN == spr_pkg::ADDR_RX_HOLD);

  // ****************************************************************
  // derived status
  // ****************************************************************
  // master idle only when nothing is held, starting or shifting
  always_comb
  begin
    if (IS_MASTER)
    begin
      shifter_idle = !sh.busy && st.tx_empty && !st.load;
    end
    else
    begin
      // slave not ready while the last word still waits to be read
      shifter_idle = sel_sync_n && !st.rx_full;
    end
  end

  assign error_flag = st.rx_ovr | st.tx_ovr;

  always_comb
  begin
    status_word                       = '0;
    status_word[spr_pkg::BIT_RX_OVR]   = st.rx_ovr;
    status_word[spr_pkg::BIT_TX_OVR]   = st.tx_ovr;
    status_word[spr_pkg::BIT_IDLE]     = shifter_idle;
    status_word[spr_pkg::BIT_TX_EMPTY] = st.tx_empty;
    status_word[spr_pkg::BIT_RX_FULL]  = st.rx_full;
    status_word[spr_pkg::BIT_ERROR]    = error_flag;
  end

  // interrupt level, enables share the status bit positions
  assign IRQ_OUT = |(status_word[spr_pkg::CTRL_W-1:0] & st.control);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    next_st      = st;
    next_st.load = 1'b0;

    // receive path: newest word always wins the holding register
    if (sh.done)
    begin
      next_st.rx_hold = sh.rx_word;
      next_st.rx_full = 1'b1;
    end
    else if (rd_rx)
    begin
      next_st.rx_full = 1'b0;
    end

    // a read in the same cycle retrieved the old word, so no overrun then
    if (sh.done && st.rx_full && !rd_rx)
    begin
      next_st.rx_ovr = 1'b1;
    end
    else if (wr_stat)
    begin
      next_st.rx_ovr = 1'b0;
    end

    // transmit path: hand the held word over once the engine is free
    if (!st.tx_empty && !sh.busy && !st.load)
    begin
      next_st.load      = 1'b1;
      next_st.load_data = st.tx_hold;
      next_st.tx_empty  = 1'b1;
    end

    // host write to transmit holding
    if (wr_tx && st.tx_empty)
    begin
      next_st.tx_hold  = WDATA_IN[spr_pkg::DATA_W-1:0];
      next_st.tx_empty = 1'b0;
    end

    // write while full keeps the old word; set beats a status clear
    if (wr_tx && !st.tx_empty)
    begin
      next_st.tx_ovr   = 1'b1;
      next_st.tx_empty = st.tx_empty || next_st.tx_empty;
    end
    else if (wr_stat)
    begin
      next_st.tx_ovr = 1'b0;
    end

    // control holds only its defined bits
    if (wr_ctrl)
    begin
      next_st.control = WDATA_IN[spr_pkg::CTRL_W-1:0] & spr_pkg::CTRL_WMASK;
      if (!IS_MASTER)
      begin
        next_st.control[spr_pkg::BIT_FORCE] = 1'b0;
      end
    end

    if (wr_sel)
    begin
      next_st.sel_mask = WDATA_IN[spr_pkg::SEL_W-1:0];
    end

    // selects follow the mask while shifting or when forced
    if (IS_MASTER && (sh.busy || st.control[spr_pkg::BIT_FORCE]))
    begin
      next_st.sel_n = ~st.sel_mask;
    end
    else
    begin
      next_st.sel_n = '1;
    end

    // read mux, status reads change nothing
    if (RD_IN)
    begin
      case (ADDR_IN)
        spr_pkg::ADDR_RX_HOLD:
        begin
          next_st.rdata = spr_pkg::BUS_W'(st.rx_hold);
        end
        spr_pkg::ADDR_STATUS:
        begin
          next_st.rdata = status_word;
        end
        spr_pkg::ADDR_CONTROL:
        begin
          next_st.rdata = spr_pkg::BUS_W'(st.control);
        end
        spr_pkg::ADDR_SEL:
        begin
          next_st.rdata = IS_MASTER ? spr_pkg::BUS_W'(st.sel_mask) : '0;
        end
        default:
        begin
          // reserved slot, transmit holding and unused addresses
          next_st.rdata = spr_pkg::RSVD_READ;
        end
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge CLOCK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      st           <= '0;
      st.tx_empty  <= 1'b1;
      st.control   <= spr_pkg::CTRL_RESET;
      st.sel_mask  <= spr_pkg::SEL_RESET;
      st.sel_n     <= '1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign RDATA_OUT = st.rdata;
  assign SEL_N_OUT = st.sel_n;

endmodule

/* File: spr_core_monitor.sv */
`timescale 1ns/1ns
// ********************
// port checks of the register interface
// ********************
module spr_core_monitor (
  input wire logic        CLOCK_IN,
  input wire logic        NRST_IN,
  input wire logic [2:0]  ADDR_IN,
  input wire logic        RD_IN,
  input wire logic        WR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic        IRQ_OUT,
  input wire logic        SCLK_OUT,
  input wire logic [7:0]  SEL_N_OUT
);
  // one domain, so clock and reset are given once
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!NRST_IN);

  a_rdata_hold: assert property (!RD_IN |=> $stable(RDATA_OUT))
    else $error("read data moved without a read");
  a_rsvd_zero: assert property (RD_IN && ADDR_IN == 3'h4 |=> RDATA_OUT == 32'h0)
    else $error("reserved slot read not zero");
  a_upper_zero: assert property (RD_IN && ADDR_IN == 3'h0 |=> RDATA_OUT[31:8] == 24'h0)
    else $error("undefined receive bits not zero");
  a_error_or: assert property (RD_IN && ADDR_IN == 3'h2
    |=> RDATA_OUT[8] == (RDATA_OUT[3] | RDATA_OUT[4]))
    else $error("error flag not the or of overruns");
  a_rx_clears: assert property (RD_IN && ADDR_IN == 3'h0 ##2 RD_IN && ADDR_IN == 3'h2
    |=> !RDATA_OUT[7])
    else $error("receive full survived a read");
  a_status_clear: assert property (WR_IN && ADDR_IN == 3'h2 ##2 RD_IN && ADDR_IN == 3'h2
    |=> RDATA_OUT[4:3] == 2'h0 && !RDATA_OUT[8])
    else $error("status write left error flags");
  a_irq_off: assert property (WR_IN && ADDR_IN == 3'h3 && WDATA_IN[10:0] == 11'h0
    |=> !IRQ_OUT)
    else $error("interrupt with all enables off");
  a_sel_shift: assert property ($rose(SCLK_OUT) |-> SEL_N_OUT != 8'hff)
    else $error("serial clock with no target selected");
endmodule

bind spr_core spr_core_monitor spr_core_monitor_inst (.CLOCK_IN(CLOCK_IN), .NRST_IN(NRST_IN),
  .ADDR_IN(ADDR_IN), .RD_IN(RD_IN), .WR_IN(WR_IN), .WDATA_IN(WDATA_IN), .RDATA_OUT(RDATA_OUT),
  .IRQ_OUT(IRQ_OUT), .SCLK_OUT(SCLK_OUT), .SEL_N_OUT(SEL_N_OUT));

/* File: spr_core_test.sv */
`timescale 1ns/1ns
// ********************
// self-checking bench of the register interface
// ********************
module spr_core_test;
  logic        clk = 1'b0;      // core clock, 40 ns
  logic        nrst = 1'b0;     // reset, low
  logic [2:0]  addr = 3'h0;     // word address
  logic        rd_en = 1'b0;    // read strobe
  logic        wr_en = 1'b0;    // write strobe
  logic [31:0] wdata = 32'h0;   // write data
  logic [31:0] rdata;           // read data
  logic        irq;             // interrupt request
  logic        sclk;            // serial clock
  logic        mosi;            // serial out
  logic        miso;            // serial in
  logic [7:0]  sel_n;           // target selects
  logic [7:0]  heard;           // what the target collected
  logic [31:0] s;               // scratch read value
  int          miscompares = 0;
  int          checked = 0;

  always #20 clk = ~clk;

  spr_core spr_core_inst (.CLOCK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr), .RD_IN(rd_en),
    .WR_IN(wr_en), .WDATA_IN(wdata), .RDATA_OUT(rdata), .IRQ_OUT(irq), .SCLK_OUT(sclk),
    .MOSI_OUT(mosi), .MISO_IN(miso), .SEL_N_IN(1'b1), .SEL_N_OUT(sel_n));
  spr_slave_model spr_slave_model_inst (.sclk_in(sclk), .sel_n_in(sel_n[0]), .mosi_in(mosi),
    .reply_in(8'h3c), .miso_out(miso), .heard_out(heard));

  // ********************
  // shared tasks
  // ********************
  task automatic conclude();
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // write, then one idle cycle so a second write never re-raises in the same step
  task automatic put(input logic [2:0] a, input logic [31:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge clk);
    #1 wr_en = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic get(input logic [2:0] a, output logic [31:0] d);
    addr = a;
    rd_en = 1'b1;
    @(posedge clk);
    #1 rd_en = 1'b0;
    @(posedge clk);
    #1 d = rdata;
  endtask
  // poll a status bit, bounded
  task automatic waitfor(input int b, input logic v);
    for (int i = 0; i < 500; i++)
    begin
      get(3'h2, s);
      if (s[b] === v)
        return;
    end
    miscompares++;
    conclude();
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_reset();
    get(3'h3, s);
    chk(s, 32'h0);
    get(3'h5, s);
    chk(s, 32'h1);
    get(3'h2, s);
    chk(s, 32'h60);
  endtask
  task automatic t_xfer();
    put(3'h1, 32'ha5);
    waitfor(7, 1'b1);
    chk({24'h0, heard}, 32'ha5);
    get(3'h0, s);
    chk(s, 32'h3c);
    get(3'h2, s);
    chk(s, 32'h60);
  endtask
  task automatic t_tx_overrun();
    addr = 3'h1;
    wdata = 32'h11;
    wr_en = 1'b1;
    @(posedge clk);
    #1 wdata = 32'h22;
    @(posedge clk);
    #1 wr_en = 1'b0;
    get(3'h2, s);
    chk(s[8:3], 6'h2a);
    waitfor(7, 1'b1);
    chk({24'h0, heard}, 32'h11);
    get(3'h0, s);
    put(3'h2, 32'h0);
    get(3'h2, s);
    chk(s, 32'h60);
  endtask
  task automatic t_back_to_back();
    put(3'h1, 32'h81);
    waitfor(6, 1'b1);
    put(3'h1, 32'h42);
    get(3'h2, s);
    chk({31'h0, s[6]}, 32'h0);
    waitfor(3, 1'b1);
    waitfor(5, 1'b1);
    chk({24'h0, heard}, 32'h42);
    get(3'h0, s);
    put(3'h2, 32'hffffffff);
    get(3'h2, s);
    chk(s, 32'h60);
  endtask
  task automatic t_misc();
    put(3'h3, 32'h40);
    chk({31'h0, irq}, 32'h1);
    get(3'h3, s);
    chk(s, 32'h40);
    put(3'h3, 32'h0);
    chk({31'h0, irq}, 32'h0);
    put(3'h4, 32'hffffffff);
    put(3'h0, 32'hffffffff);
    get(3'h4, s);
    chk(s, 32'h0);
    get(3'h2, s);
    chk(s, 32'h60);
    put(3'h5, 32'h05);
    put(3'h3, 32'h400);
    chk({24'h0, sel_n}, 32'hfa);
    put(3'h3, 32'h0);
    chk({24'h0, sel_n}, 32'hff);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    t_reset();
    t_xfer();
    t_tx_overrun();
    t_back_to_back();
    t_misc();
    conclude();
  end
endmodule

/* File: spr_if.sv */
`timescale 1ns/1ns
// ****************************************************************
// link between register side and shift engine
// ****************************************************************
interface spr_shift_if;
  logic                        load;       // one-cycle start pulse
  logic [spr_pkg::DATA_W-1:0]  load_data;  // word to send
  logic                        busy;       // engine shifting
  logic                        done;       // one-cycle word finished
  logic [spr_pkg::DATA_W-1:0]  rx_word;    // word received

  modport core   (output load, output load_data, input busy, input done, input rx_word);
  modport engine (input load, input load_data, output busy, output done, output rx_word);
endinterface

/* File: spr_pkg.sv */
// ****************************************************************
// shared constants of the serial core register interface
// ****************************************************************
package spr_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int DATA_W   = 8;   // serial data width n
  localparam int SEL_W    = 8;   // number of target select outputs
  localparam int BUS_W    = 32;  // host data bus width
  localparam int ADDR_W   = 3;   // internal word address width
  localparam int CTRL_W   = 11;  // control bits held, 10 down to 0
  localparam int BITCNT_W = 4;   // serial bit counter width

  // ****************************************************************
  // internal word addresses
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADDR_RX_HOLD = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_TX_HOLD = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_RSVD    = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_SEL     = 3'h5;

  // ****************************************************************
  // status and control bit positions
  // ****************************************************************
  localparam int BIT_RX_OVR   = 3;   // receive_overrun_flag
  localparam int BIT_TX_OVR   = 4;   // transmit_overrun_flag
  localparam int BIT_IDLE     = 5;   // shifter_idle_flag
  localparam int BIT_TX_EMPTY = 6;   // transmit_empty_flag
  localparam int BIT_RX_FULL  = 7;   // receive_full_flag
  localparam int BIT_ERROR    = 8;   // error summary / error_irq_enable
  localparam int BIT_FORCE    = 10;  // force target select

  // writable control bits: enables at 3,4,6,7,8 and force at 10
  localparam logic [CTRL_W-1:0] CTRL_WMASK   = 11'h5d8;
  localparam logic [CTRL_W-1:0] CTRL_RESET   = 11'h000;
  localparam logic [SEL_W-1:0]  SEL_RESET    = 8'h01;
  localparam logic [BUS_W-1:0]  RSVD_READ    = 32'h00000000;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 40;  // core clock period
  // the half period must outlast the three-flop input path plus the agreement
  // stage, or the rising edge would sample the bit of the previous slot
  localparam int SCLK_HALF_NS   = 240; // least half period of serial clock
  localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [BITCNT_W-1:0] HALF_LAST = BITCNT_W'(SCLK_HALF_CYC - 1);
  localparam logic [BITCNT_W-1:0] BITS_LAST = BITCNT_W'(DATA_W - 1);

  // ****************************************************************
  // shift engine states, one-hot
  // ****************************************************************
  typedef enum logic [2:0] {
    SH_IDLE = 3'h1,
    SH_LOW  = 3'h2,
    SH_HIGH = 3'h4
  } spr_shift_state_t;

endpackage

/* File: spr_shift.sv */
`timescale 1ns/1ns
// ****************************************************************
// master shift engine, idle-low clock, sample on rising edge
// ****************************************************************
module spr_shift (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  spr_shift_if.engine     sh,
  input  wire logic       miso_in,   // already synchronised
  output logic            sclk_out,
  output logic            mosi_out
);

  typedef struct packed {
    spr_pkg::spr_shift_state_t        state;
    logic [spr_pkg::BITCNT_W-1:0]     div;    // half-period counter
    logic [spr_pkg::BITCNT_W-1:0]     bits;   // bits done
    logic [spr_pkg::DATA_W-1:0]       shreg;  // out at msb, in at lsb
    logic [spr_pkg::DATA_W-1:0]       rx;     // last received word
    logic                             sclk;
    logic                             mosi;
    logic                             done;
  } spr_shift_st_t;

  spr_shift_st_t st;
  spr_shift_st_t next_st;

  // one half period per phase; the word completes on the last falling edge
  always_comb
  begin
    next_st      = st;
    next_st.done = 1'b0;
    next_st.div  = st.div + 1'b1;
    case (st.state)
      spr_pkg::SH_IDLE:
      begin
        next_st.div = '0;
        if (sh.load)
        begin
          next_st.shreg = sh.load_data;
          next_st.mosi  = sh.load_data[spr_pkg::DATA_W-1];
          next_st.bits  = '0;
          next_st.state = spr_pkg::SH_LOW;
        end
      end
      spr_pkg::SH_LOW:
      begin
        // rising edge: sample the incoming bit
        if (st.div == spr_pkg::HALF_LAST)
        begin
          next_st.div   = '0;
          next_st.sclk  = 1'b1;
          next_st.shreg = {st.shreg[spr_pkg::DATA_W-2:0], miso_in};
          next_st.state = spr_pkg::SH_HIGH;
        end
      end
      spr_pkg::SH_HIGH:
      begin
        // falling edge: present next bit or finish
        if (st.div == spr_pkg::HALF_LAST)
        begin
          next_st.div  = '0;
          next_st.sclk = 1'b0;
          if (st.bits == spr_pkg::BITS_LAST)
          begin
            next_st.rx    = st.shreg;
            next_st.done  = 1'b1;
            next_st.mosi  = 1'b0;
            next_st.state = spr_pkg::SH_IDLE;
          end
          else
          begin
            next_st.bits  = st.bits + 1'b1;
            next_st.mosi  = st.shreg[spr_pkg::DATA_W-1];
            next_st.state = spr_pkg::SH_LOW;
          end
        end
      end
      default:
      begin
        next_st.state = spr_pkg::SH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st <= '{spr_pkg::SH_IDLE, '0, '0, '0, '0, 1'b0, 1'b0, 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sh.busy    = (st.state != spr_pkg::SH_IDLE);
  assign sh.done    = st.done;
  assign sh.rx_word = st.rx;
  assign sclk_out   = st.sclk;
  assign mosi_out   = st.mosi;

endmodule

/* File: spr_slave_model.sv */
`timescale 1ns/1ns
// ********************
// serial target, idle-low clock, data out on falling edge
// ********************
module spr_slave_model (
  input  wire logic       sclk_in,   // serial clock from the core
  input  wire logic       sel_n_in,  // this target's select, low
  input  wire logic       mosi_in,   // data from the core
  input  wire logic [7:0] reply_in,  // word to answer with
  output logic            miso_out,  // data to the core
  output logic [7:0]      heard_out  // last eight bits collected
);
  logic [7:0] shreg;  // outgoing bits, msb first

  initial
  begin
    miso_out = 1'b0;
    heard_out = 8'h00;
    shreg = 8'h00;
  end
  // first bit appears as soon as we are selected
  always @(negedge sel_n_in)
  begin
    shreg = reply_in;
    miso_out = reply_in[7];
  end
  // released line: show the inverse so a stale bit never passes
  always @(posedge sel_n_in) miso_out = ~miso_out;
  // collect on the rising edge
  always @(posedge sclk_in) heard_out = {heard_out[6:0], mosi_in};
  // next bit after each falling edge while selected
  always @(negedge sclk_in)
    if (!sel_n_in)
    begin
      shreg = {shreg[6:0], 1'b0};
      miso_out = shreg[7];
    end
endmodule

/* File: spr_sync3.sv */
`timescale 1ns/1ns
// ****************************************************************
// three-stage input synchroniser with agreement filter
// ****************************************************************
module spr_sync3 #(
  parameter logic IDLE_LEVEL = 1'b1  // level shown from reset
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic pin_in,
  output logic      level_out
);

  typedef struct packed {
    logic s1;  // first stage, read only by s2
    logic s2;
    logic s3;
    logic q;   // accepted level
  } spr_sync_state_t;

  spr_sync_state_t st;
  spr_sync_state_t next_st;

  // a change is accepted only once stages two and three agree
  always_comb
  begin
    next_st    = st;
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3)
    begin
      next_st.q = st.s3;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st <= '{IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign level_out = st.q;

endmodule
